// ### uphy_pkg.sv
package uphy_pkg;

  // Register byte offsets on the APB window.
  localparam logic [7:0] OFF_DEV_ADDR = 8'h08;
  localparam logic [7:0] OFF_FCTL     = 8'h0C;
  localparam logic [7:0] OFF_OTG_CTL  = 8'h10;
  localparam logic [7:0] OFF_OTG_FLG  = 8'h14;
  localparam logic [7:0] OFF_SER_CTL  = 8'h18;
  localparam logic [7:0] OFF_FLAGS    = 8'h1C;
  localparam logic [7:0] OFF_STICKY   = 8'h20;
  localparam logic [7:0] OFF_MASKS    = 8'h24;
  localparam logic [7:0] OFF_FRAME    = 8'h28;
  localparam logic [7:0] OFF_PID      = 8'h2C;
  localparam logic [7:0] OFF_EP       = 8'h30;
  localparam logic [7:0] OFF_EP_MATCH = 8'h34;
  localparam logic [7:0] OFF_OTG_MASK = 8'h38;

  // Reset values: opmode 1, termselect 1, xcvrselect 1; tx enable_n 1.
  localparam logic [4:0] FCTL_RST = 5'h07;
  localparam logic [3:0] SER_RST  = 4'h2;

  // Event flag bit positions.
  localparam int FLG_TOK = 6;
  localparam int FLG_SE0 = 5;
  localparam int FLG_K   = 4;
  localparam int FLG_J   = 3;
  localparam int FLG_CRC = 2;
  localparam int FLG_RXA = 1;
  localparam int FLG_RXE = 0;
  localparam int NFLAGS  = 7;

  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J   = 2'h1;
  localparam logic [1:0] LS_K   = 2'h2;

  localparam logic [3:0] PID_SOF  = 4'h5;
  localparam logic [1:0] PT_TOKEN = 2'h1;
  localparam logic [1:0] PT_DATA  = 2'h3;

  // CRCs are run LSB first in reflected form.
  localparam logic [4:0]  CRC5_INIT  = 5'h1F;
  localparam logic [4:0]  CRC5_POLY  = 5'h14;
  localparam logic [4:0]  CRC5_RES   = 5'h06;
  localparam logic [15:0] CRC16_INIT = 16'hFFFF;
  localparam logic [15:0] CRC16_POLY = 16'hA001;
  localparam logic [15:0] CRC16_RES  = 16'hB001;
  localparam logic [4:0]  EP_SPECIAL = 5'h10;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
    logic       active;
    logic       error;
    logic [1:0] linestate;
  } uphy_rx_t;

  typedef struct packed {
    logic bvalid;
    logic idgnd;
    logic hostdis;
    logic vbusvld;
    logic sessvld;
    logic sessend;
  } uphy_otg_t;

  typedef struct packed {
    logic rxrcv;
    logic rxdm;
    logic rxdp;
  } uphy_ser_t;

  typedef enum logic [1:0] {ST_IDLE, ST_PID, ST_BODY} uphy_st_t;

endpackage : uphy_pkg

// ### uphy_ctrl.sv
// Local design decision: the APB slave port.
`timescale 1ns/1ps

// Summary of operation
// - Opmode output from three-bit field, resets one.
// - Termselect bit1, xcvrselect bit0, both reset one.
// - Bits 7,6 enable external VBUS modes.
// - Bits 4..0 drive VBUS and pull controls.
// - OTG flags register shows live transceiver status.
// - Serial receive inputs readable in bits 6..4.
// - Bits 3,2 drive serial SE0 and data.
// - Bit 1 is active-low transmit enable, resets one.
// - Bit 0 selects FS/LS serial mode.
// - Flag 6 set on good addressed token.
// - Flags 5,4,3 set on SE0, K, J.
// - Flag 2 set on data CRC16 failure.
// - Flags 1,0 follow RxActive and RxError.
// - Normal flags 6..2 clear on next packet; sticky hold.
// - Sticky bit per flag; cleared by writing one.
// - Three ports high when masked flag high.
// - Eleven-bit writable frame counter, resets zero.
// - Last received PID captured, read-only.
// - Last endpoint and its valid bit captured.
// - Special endpoints delivered ORed with 0x10.
// - Tokens other than SOF pass only for programmed device address.
module uphy_ctrl (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              pce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire uphy_pkg::uphy_rx_t  utmi_rx,
  input  wire uphy_pkg::uphy_otg_t utmi_otg,
  input  wire uphy_pkg::uphy_ser_t utmi_ser,
  output logic [2:0]             opmode,
  output logic                   termselect,
  output logic                   xcvrselect,
  output logic                   external_vbus_indicator_mode,
  output logic                   external_vbus_drive_mode,
  output logic                   chrgvbus,
  output logic                   dischrgvbus,
  output logic                   dmpulldown,
  output logic                   dppulldown,
  output logic                   idpullup,
  output logic                   tx_se0,
  output logic                   tx_dat,
  output logic                   tx_enable_n,
  output logic                   fsls_serial,
  output logic                   first_flag_output_port,
  output logic                   second_flag_output_port,
  output logic                   third_flag_output_port,
  output logic [4:0]             rx_ep,
  output logic                   rx_ep_valid
);
  import uphy_pkg::*;

  function automatic logic [4:0] crc5_f(input logic [15:0] d);
    logic [4:0] c;
    c = CRC5_INIT;
    for (int i = 0; i < 16; i++) begin
      c = (c >> 1) ^ ((d[i] ^ c[0]) ? CRC5_POLY : 5'h00);
    end
    return c;
  endfunction : crc5_f

  function automatic logic [15:0] crc16_f(input logic [15:0] c0,
                                          input logic [7:0]  d);
    logic [15:0] c;
    c = c0;
    for (int i = 0; i < 8; i++) begin
      c = (c >> 1) ^ ((d[i] ^ c[0]) ? CRC16_POLY : 16'h0000);
    end
    return c;
  endfunction : crc16_f

  logic [4:0]        fctl_ff;
  logic [7:0]        otgc_ff;
  logic [3:0]        ser_ff;
  logic [6:0]        dev_addr_ff;
  logic [NFLAGS-1:0] flags_ff;
  logic [NFLAGS-1:0] nxt_flags;
  logic [NFLAGS-1:0] sticky_ff;
  logic [31:0]       masks_ff;
  logic [10:0]       frame_ff;
  logic [3:0]        pid_ff;
  logic [4:0]        ep_ff;
  logic [15:0]       ep_match_ff;
  logic [31:0]       otg_mask_ff;
  logic              pready_ff;
  logic [31:0]       prdata_ff;
  logic              pslverr_ff;
  logic [2:0]        port_ff;
  logic [4:0]        rx_ep_ff;
  logic              rx_ep_valid_ff;
  uphy_st_t          st_ff;
  logic [7:0]        pidb_ff;
  logic [7:0]        b1_ff;
  logic [7:0]        b2_ff;
  logic [1:0]        cnt_ff;
  logic [15:0]       crc16_ff;
  logic              rxa_ff;
  logic [1:0]        ls_ff;

  // APB: one wait state, so registers settle before read data is latched.
  wire access  = psel & penable;
  wire xfer    = access & pready_ff;
  wire wr      = xfer & pwrite;
  wire wr_dadr = wr & (paddr == OFF_DEV_ADDR);
  wire wr_fctl = wr & (paddr == OFF_FCTL);
  wire wr_otgc = wr & (paddr == OFF_OTG_CTL);
  wire wr_ser  = wr & (paddr == OFF_SER_CTL);
  wire wr_flg  = wr & (paddr == OFF_FLAGS);
  wire wr_stk  = wr & (paddr == OFF_STICKY);
  wire wr_msk  = wr & (paddr == OFF_MASKS);
  wire wr_frm  = wr & (paddr == OFF_FRAME);
  wire wr_epm  = wr & (paddr == OFF_EP_MATCH);
  wire wr_otgm = wr & (paddr == OFF_OTG_MASK);

  wire mapped = (paddr[1:0] == 2'h0) &
                (paddr >= OFF_DEV_ADDR) & (paddr <= OFF_OTG_MASK);

  // Narrow fields sit low and reserved bits read zero.
  wire [31:0] rd_mux =
    (paddr == OFF_DEV_ADDR) ? {25'h0, dev_addr_ff} :
    (paddr == OFF_FCTL)     ? {27'h0, fctl_ff} :
    (paddr == OFF_OTG_CTL)  ? {24'h0, otgc_ff[7:6], 1'b0,
                               otgc_ff[4:0]} :
    (paddr == OFF_OTG_FLG)  ? {26'h0, utmi_otg} :
    (paddr == OFF_SER_CTL)  ? {25'h0, utmi_ser, ser_ff} :
    (paddr == OFF_FLAGS)    ? {25'h0, flags_ff} :
    (paddr == OFF_STICKY)   ? {25'h0, sticky_ff} :
    (paddr == OFF_MASKS)    ? masks_ff :
    (paddr == OFF_FRAME)    ? {21'h0, frame_ff} :
    (paddr == OFF_PID)      ? {28'h0, pid_ff} :
    (paddr == OFF_EP)       ? {27'h0, ep_ff} :
    (paddr == OFF_EP_MATCH) ? {16'h0, ep_match_ff} :
    (paddr == OFF_OTG_MASK) ? otg_mask_ff : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (pce) begin
      pready_ff  <= access & ~pready_ff;
      prdata_ff  <= (access & ~pready_ff & ~pwrite) ? rd_mux : prdata_ff;
      pslverr_ff <= access & ~pready_ff & ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fctl_ff     <= FCTL_RST;
      otgc_ff     <= 8'h00;
      ser_ff      <= SER_RST;
      dev_addr_ff <= 7'h00;
      sticky_ff   <= 7'h00;
      masks_ff    <= 32'h0000_0000;
      ep_match_ff <= 16'h0000;
      otg_mask_ff <= 32'h0000_0000;
    end else if (pce) begin
      if (wr_fctl) fctl_ff <= pwdata[4:0];
      if (wr_otgc) otgc_ff <= pwdata[7:0] & 8'hDF;
      if (wr_ser) ser_ff <= pwdata[3:0];
      if (wr_dadr) dev_addr_ff <= pwdata[6:0];
      if (wr_stk) sticky_ff <= pwdata[6:0];
      if (wr_msk) masks_ff <= pwdata;
      if (wr_epm) ep_match_ff <= pwdata[15:0];
      if (wr_otgm) otg_mask_ff <= pwdata;
    end
  end

  // Packet receive path.
  wire rx_rise  = utmi_rx.active & ~rxa_ff;
  wire rx_fall  = ~utmi_rx.active & rxa_ff;
  wire rx_byte  = utmi_rx.valid & utmi_rx.active;
  wire pkt_end  = rx_fall & (st_ff == ST_BODY);
  wire pid_ok   = pidb_ff[3:0] == ~pidb_ff[7:4];
  wire is_tok   = pidb_ff[1:0] == PT_TOKEN;
  wire is_data  = pidb_ff[1:0] == PT_DATA;
  wire is_sof   = pidb_ff[3:0] == PID_SOF;
  wire crc5_ok  = crc5_f({b2_ff, b1_ff}) == CRC5_RES;
  wire addr_ok  = b1_ff[6:0] == dev_addr_ff;
  wire tok_good = pkt_end & pid_ok & (cnt_ff == 2'h2) & crc5_ok;
  wire tok_ok   = tok_good & is_tok & ~is_sof & addr_ok;
  wire sof_ok   = tok_good & is_sof;
  wire crc_err  = pkt_end & pid_ok & is_data &
                  (crc16_ff != CRC16_RES);
  wire [3:0] ep_num = {b2_ff[2:0], b1_ff[7]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff    <= ST_IDLE;
      pidb_ff  <= 8'h00;
      b1_ff    <= 8'h00;
      b2_ff    <= 8'h00;
      cnt_ff   <= 2'h0;
      crc16_ff <= CRC16_INIT;
      rxa_ff   <= 1'b0;
      ls_ff    <= LS_J;
    end else if (pce) begin
      rxa_ff <= utmi_rx.active;
      ls_ff  <= utmi_rx.linestate;
      case (st_ff)
        ST_IDLE: begin
          if (rx_rise) st_ff <= ST_PID;
        end
        ST_PID: begin
          cnt_ff   <= 2'h0;
          crc16_ff <= CRC16_INIT;
          if (rx_byte) begin
            pidb_ff <= utmi_rx.data;
            st_ff   <= ST_BODY;
          end else if (!utmi_rx.active) begin
            st_ff <= ST_IDLE;
          end
        end
        ST_BODY: begin
          if (rx_byte) begin
            crc16_ff <= crc16_f(crc16_ff, utmi_rx.data);
            if (cnt_ff == 2'h0) b1_ff <= utmi_rx.data;
            if (cnt_ff == 2'h1) b2_ff <= utmi_rx.data;
            // Saturate so that an overlong token never matches.
            if (cnt_ff != 2'h3) cnt_ff <= cnt_ff + 2'h1;
          end
          if (!utmi_rx.active) st_ff <= ST_IDLE;
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // Captured packet fields; a SOF load beats a software write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_ff       <= 11'h000;
      pid_ff         <= 4'h0;
      ep_ff          <= 5'h00;
      rx_ep_ff       <= 5'h00;
      rx_ep_valid_ff <= 1'b0;
    end else if (pce) begin
      if (sof_ok) frame_ff <= {b2_ff[2:0], b1_ff};
      else if (wr_frm) frame_ff <= pwdata[10:0];
      if (st_ff == ST_PID && rx_byte) pid_ff <= utmi_rx.data[3:0];
      if (tok_ok) ep_ff <= {1'b1, ep_num};
      if (tok_ok) begin
        rx_ep_ff <= ep_match_ff[ep_num] ? ({1'b0, ep_num} | EP_SPECIAL)
                                        : {1'b0, ep_num};
      end
      rx_ep_valid_ff <= tok_ok;
    end
  end

  // Line state flags fire on a change; idle J after reset is no change.
  wire ls_chg = utmi_rx.linestate != ls_ff;
  wire [NFLAGS-1:0] ev = {
    tok_ok,
    ls_chg & (utmi_rx.linestate == LS_SE0),
    ls_chg & (utmi_rx.linestate == LS_K),
    ls_chg & (utmi_rx.linestate == LS_J),
    crc_err,
    utmi_rx.active,
    utmi_rx.error};
  wire [NFLAGS-1:0] clr = wr_flg ? pwdata[NFLAGS-1:0] : 7'h00;
  // A new event in the clear cycle wins over the clear.
  wire [NFLAGS-1:0] stk_nxt = (flags_ff & ~clr) | ev;
  wire [NFLAGS-1:0] nrm_nxt = {
    (flags_ff[6:2] & ~{5{rx_rise}} & ~clr[6:2]) | ev[6:2],
    ev[1:0]};

  assign nxt_flags = (sticky_ff & stk_nxt) | (~sticky_ff & nrm_nxt);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= 7'h00;
      port_ff  <= 3'h0;
    end else if (pce) begin
      flags_ff   <= nxt_flags;
      port_ff[0] <= |(flags_ff & masks_ff[6:0]);
      port_ff[1] <= |(flags_ff & masks_ff[14:8]);
      port_ff[2] <= |(flags_ff & masks_ff[22:16]);
    end
  end

  assign prdata                       = prdata_ff;
  assign pready                       = pready_ff;
  assign pslverr                      = pslverr_ff;
  assign opmode                       = fctl_ff[4:2];
  assign termselect                   = fctl_ff[1];
  assign xcvrselect                   = fctl_ff[0];
  assign external_vbus_indicator_mode = otgc_ff[7];
  assign external_vbus_drive_mode     = otgc_ff[6];
  assign chrgvbus                     = otgc_ff[4];
  assign dischrgvbus                  = otgc_ff[3];
  assign dmpulldown                   = otgc_ff[2];
  assign dppulldown                   = otgc_ff[1];
  assign idpullup                     = otgc_ff[0];
  assign tx_se0                       = ser_ff[3];
  assign tx_dat                       = ser_ff[2];
  assign tx_enable_n                  = ser_ff[1];
  assign fsls_serial                  = ser_ff[0];
  assign first_flag_output_port       = port_ff[0];
  assign second_flag_output_port      = port_ff[1];
  assign third_flag_output_port       = port_ff[2];
  assign rx_ep                        = rx_ep_ff;
  assign rx_ep_valid                  = rx_ep_valid_ff;

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_wait;
    psel && penable && !pready_ff && pce;
  endsequence

  a_apb_wait_state: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup ##1 s_wait |=> pready_ff)
    else $error("APB access did not complete after one wait state");

  a_fctl_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fctl && pce) |=> opmode == $past(pwdata[4:2]) &&
    {termselect, xcvrselect} == $past(pwdata[1:0]))
    else $error("Function control write not driven to outputs");

  a_otg_modes: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_otgc && pce) |=> {external_vbus_indicator_mode,
    external_vbus_drive_mode} == $past(pwdata[7:6]))
    else $error("External VBUS mode bits not driven");

  a_otg_pins: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_otgc && pce) |=> {chrgvbus, dischrgvbus, dmpulldown, dppulldown,
    idpullup} == $past(pwdata[4:0]))
    else $error("OTG pin controls not driven");

  a_serial_tx: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ser && pce) |=> {tx_se0, tx_dat, tx_enable_n, fsls_serial}
    == $past(pwdata[3:0]))
    else $error("Serial control bits not driven");

  a_token_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (tok_ok && pce) |=> flags_ff[FLG_TOK] && rx_ep_valid)
    else $error("Good token did not raise its flag");

  a_crc_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (crc_err && pce) |=> flags_ff[FLG_CRC])
    else $error("CRC16 failure did not raise its flag");

  a_rx_follow: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && !sticky_ff[FLG_RXA]) |=>
    flags_ff[FLG_RXA] == $past(utmi_rx.active))
    else $error("RxActive flag does not follow its input");

  a_sticky_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && sticky_ff[FLG_J] && flags_ff[FLG_J] && !clr[FLG_J])
    |=> flags_ff[FLG_J])
    else $error("Sticky flag dropped without a clear");

  a_port_or: assert property (@(posedge pclk) disable iff (!presetn)
    pce |=> third_flag_output_port ==
    |($past(flags_ff) & $past(masks_ff[22:16])))
    else $error("Third flag port disagrees with masked flags");

endmodule : uphy_ctrl

// ### uphy_xcvr_model.sv
`timescale 1ns/1ps

module uphy_xcvr_model (
  input  wire logic          pclk,
  output uphy_pkg::uphy_rx_t  utmi_rx,
  output uphy_pkg::uphy_otg_t utmi_otg,
  output uphy_pkg::uphy_ser_t utmi_ser
);
  import uphy_pkg::*;

  initial begin
    utmi_rx           = '0;
    utmi_rx.linestate = LS_J;
    utmi_otg          = '0;
    utmi_ser          = '0;
  end

  // The data bus outside a valid byte shows a changing pattern, so a design
  // that samples it without valid cannot pass by luck.
  task automatic send(input logic [23:0] b, input int n, input int gap);
    int i;
    int g;
    @(posedge pclk);
    utmi_rx.active <= 1'b1;
    for (i = 0; i < n; i++) begin
      for (g = 0; g < gap; g++) begin
        @(posedge pclk);
        utmi_rx.valid <= 1'b0;
        utmi_rx.data  <= ~utmi_rx.data;
      end
      @(posedge pclk);
      utmi_rx.valid <= 1'b1;
      utmi_rx.data  <= b[8*i +: 8];
    end
    @(posedge pclk);
    utmi_rx.valid  <= 1'b0;
    utmi_rx.active <= 1'b0;
    utmi_rx.data   <= ~b[8*(n-1) +: 8];
  endtask : send

  task automatic set_rx(input logic act, input logic err);
    @(posedge pclk);
    utmi_rx.active <= act;
    utmi_rx.error  <= err;
  endtask : set_rx

  task automatic set_ls(input logic [1:0] ls);
    @(posedge pclk);
    utmi_rx.linestate <= ls;
  endtask : set_ls

  task automatic set_stat(input uphy_otg_t o, input uphy_ser_t s);
    @(posedge pclk);
    utmi_otg <= o;
    utmi_ser <= s;
  endtask : set_stat
endmodule : uphy_xcvr_model

// ### usb_phy_interface_control_tb_top.sv
`timescale 1ns/1ps

module usb_phy_interface_control_tb_top;
  import uphy_pkg::*;
  logic        pclk, presetn, pce, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  uphy_rx_t    rx;
  uphy_otg_t   otg;
  uphy_ser_t   ser;
  logic [2:0]  opmode;
  logic        termselect, xcvrselect, ev_ind, ev_drv, chrg, dischrg;
  logic        dmpd, dppd, idpu, tx_se0, tx_dat, tx_enable_n, fsls;
  logic        port1, port2, port3, rx_ep_valid, se;
  logic [4:0]  rx_ep;
  logic [15:0] outs;
  int          err_count, cmp_count;
  logic [7:0]  ra [13] = '{OFF_DEV_ADDR, OFF_FCTL, OFF_OTG_CTL, OFF_OTG_FLG,
    OFF_SER_CTL, OFF_FLAGS, OFF_STICKY, OFF_MASKS, OFF_FRAME, OFF_PID,
    OFF_EP, OFF_EP_MATCH, OFF_OTG_MASK};
  logic [31:0] e_rst [13] = '{0, 32'h07, 0, 0, 32'h02, 0, 0, 0, 0, 0, 0, 0, 0};
  logic [31:0] e_one [13] = '{32'h7F, 32'h1F, 32'hDF, 32'h2A, 32'h5F, 0,
    32'h7F, 32'hFFFFFFFF, 32'h7FF, 0, 0, 32'hFFFF, 32'hFFFFFFFF};
  logic [31:0] e_zro [13] = '{0, 0, 0, 32'h2A, 32'h50, 0, 0, 0, 0, 0, 0, 0, 0};

  assign outs = {opmode, termselect, xcvrselect, ev_ind, ev_drv, chrg,
                 dischrg, dmpd, dppd, idpu, tx_se0, tx_dat, tx_enable_n, fsls};

  uphy_ctrl u_uphy_ctrl (.pclk(pclk), .presetn(presetn), .pce(pce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .utmi_rx(rx), .utmi_otg(otg), .utmi_ser(ser), .opmode(opmode),
    .termselect(termselect), .xcvrselect(xcvrselect),
    .external_vbus_indicator_mode(ev_ind), .external_vbus_drive_mode(ev_drv),
    .chrgvbus(chrg), .dischrgvbus(dischrg), .dmpulldown(dmpd),
    .dppulldown(dppd), .idpullup(idpu), .tx_se0(tx_se0), .tx_dat(tx_dat),
    .tx_enable_n(tx_enable_n), .fsls_serial(fsls),
    .first_flag_output_port(port1), .second_flag_output_port(port2),
    .third_flag_output_port(port3), .rx_ep(rx_ep), .rx_ep_valid(rx_ep_valid));

  uphy_xcvr_model u_uphy_xcvr_model (.pclk(pclk), .utmi_rx(rx),
    .utmi_otg(otg), .utmi_ser(ser));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Read data and the error flag are taken at the edge that sees pready.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      err_count++;
      conclude();
    end
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_ep(input logic exp_seen, input logic [4:0] exp_ep);
    int i;
    logic seen;
    seen = 1'b0;
    for (i = 0; i < 12; i++) begin
      @(posedge pclk);
      if (rx_ep_valid === 1'b1 && !seen) begin
        seen = 1'b1;
        chk({27'h0, rx_ep}, {27'h0, exp_ep});
      end
    end
    chk({31'h0, seen}, {31'h0, exp_seen});
    if (exp_seen && !seen) conclude();
  endtask : wait_ep

  // USB token body with its CRC5, sent inverted and least significant first.
  function automatic logic [15:0] tok(input logic [6:0] a,
                                      input logic [3:0] e);
    logic [10:0] d;
    logic [4:0]  c;
    d = {e, a};
    c = 5'h1F;
    for (int i = 0; i < 11; i++)
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ 5'h14) : (c >> 1);
    return {~c, d};
  endfunction : tok

  task automatic t_regs();
    for (int i = 0; i < 13; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, e_rst[i]);
    end
    chk({16'h0, outs}, 32'h3802);
    u_uphy_xcvr_model.set_stat(6'h2A, 3'h5);
    for (int i = 0; i < 13; i++) begin
      apb(1'b1, ra[i], 32'hFFFFFFFF);
      apb(1'b0, ra[i], 32'h0);
      chk(rd, e_one[i]);
    end
    chk({16'h0, outs}, 32'hFFFF);
    for (int i = 0; i < 13; i++) begin
      apb(1'b1, ra[i], 32'h0);
      apb(1'b0, ra[i], 32'h0);
      chk(rd, e_zro[i]);
    end
    chk({16'h0, outs}, 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    chk({se, rd[30:0]}, 32'h80000000);
    apb(1'b1, 8'h0D, 32'hFFFFFFFF);
    chk({31'h0, se}, 32'h1);
  endtask : t_regs

  task automatic t_token();
    apb(1'b1, OFF_DEV_ADDR, 32'h05);
    apb(1'b1, OFF_EP_MATCH, 32'h0008);
    apb(1'b1, OFF_MASKS, 32'h00020440);
    u_uphy_xcvr_model.send({tok(7'h05, 4'h3), 8'hE1}, 3, 0);
    wait_ep(1'b1, 5'h13);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(rd & 32'h40, 32'h40);
    chk({31'h0, port1}, 32'h1);
    apb(1'b0, OFF_EP, 32'h0);
    chk(rd, 32'h13);
    u_uphy_xcvr_model.send({tok(7'h06, 4'h2), 8'hE1}, 3, 0);
    wait_ep(1'b0, 5'h0);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(rd & 32'h40, 32'h0);
    chk({31'h0, port1}, 32'h0);
    u_uphy_xcvr_model.send({tok(7'h05, 4'h2) ^ 16'h8000, 8'hE1}, 3, 0);
    wait_ep(1'b0, 5'h0);
    u_uphy_xcvr_model.send({tok(7'h05, 4'h2), 8'h69}, 3, 2);
    wait_ep(1'b1, 5'h02);
    apb(1'b0, OFF_EP, 32'h0);
    chk(rd, 32'h12);
    apb(1'b0, OFF_PID, 32'h0);
    chk(rd, 32'h9);
    // A frame marker loads the counter but is not a token for the flag.
    u_uphy_xcvr_model.send({tok(7'h35, 4'h5), 8'hA5}, 3, 0);
    wait_ep(1'b0, 5'h0);
    apb(1'b0, OFF_FRAME, 32'h0);
    chk(rd, 32'h2B5);
  endtask : t_token

  task automatic t_data();
    logic [23:0] good;
    logic [23:0] bad;
    good = 24'h0000C3;
    bad  = 24'h3412C3;
    u_uphy_xcvr_model.send(bad, 3, 0);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(rd & 32'h4, 32'h4);
    chk({31'h0, port2}, 32'h1);
    u_uphy_xcvr_model.send(good, 3, 1);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(rd & 32'h4, 32'h0);
    apb(1'b1, OFF_STICKY, 32'h4);
    u_uphy_xcvr_model.send(bad, 3, 0);
    u_uphy_xcvr_model.send(good, 3, 0);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(rd & 32'h4, 32'h4);
    apb(1'b1, OFF_FLAGS, 32'h4);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(rd & 32'h4, 32'h0);
    apb(1'b0, OFF_PID, 32'h0);
    chk(rd, 32'h3);
  endtask : t_data

  task automatic t_line();
    u_uphy_xcvr_model.set_ls(LS_SE0);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(rd & 32'h20, 32'h20);
    u_uphy_xcvr_model.set_ls(LS_K);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(rd & 32'h10, 32'h10);
    apb(1'b1, OFF_STICKY, 32'h0C);
    u_uphy_xcvr_model.set_ls(LS_J);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(rd & 32'h08, 32'h08);
    u_uphy_xcvr_model.set_rx(1'b1, 1'b1);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(rd & 32'hB, 32'hB);
    chk({31'h0, port3}, 32'h1);
    u_uphy_xcvr_model.set_rx(1'b0, 1'b0);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk(rd & 32'h3, 32'h0);
  endtask : t_line

  // With the clock enable low nothing may move, not even the flag ports.
  task automatic t_freeze();
    @(posedge pclk);
    pce <= 1'b0;
    u_uphy_xcvr_model.set_rx(1'b1, 1'b0);
    repeat (3) @(posedge pclk);
    chk({31'h0, port3}, 32'h0);
    pce <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'h0, port3}, 32'h1);
    u_uphy_xcvr_model.set_rx(1'b0, 1'b0);
    repeat (3) @(posedge pclk);
  endtask : t_freeze

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    presetn   = 1'b0;
    pce       = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    err_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_token();
    t_data();
    t_line();
    t_freeze();
    conclude();
  end
endmodule : usb_phy_interface_control_tb_top
